// ==== verilog/ces_pkg.sv ====
// constants and carrier types of the error status and error counter block
`default_nettype none
package ces_pkg;
   // ------------------------------------------------------------------
   // register addresses on the special function register port
   // ------------------------------------------------------------------
   localparam logic [15:0] ADDR_ERR_STATUS = 16'hffb4;
   localparam logic [15:0] ADDR_TX_ERR_CNT = 16'hffb5;
   localparam logic [15:0] ADDR_RX_ERR_CNT = 16'hffb6;
   // ------------------------------------------------------------------
   // error status register layout and reset value
   // ------------------------------------------------------------------
   localparam int BIT_BUS_OFF_FLAG = 7;
   localparam int BIT_RECEIVE_WARNING_FLAG = 6;
   localparam int BIT_TRANSMIT_WARNING_FLAG = 5;
   localparam int BIT_INIT = 3;
   localparam int BIT_VALID = 2;
   localparam int BIT_WAKE = 1;
   localparam int BIT_OVER = 0;
   localparam logic [7:0] ERR_STATUS_RST = 8'h00;
   localparam logic [7:0] CNT_RST = 8'h00;
   // ------------------------------------------------------------------
   // fault confinement figures
   // ------------------------------------------------------------------
   localparam int TEC_W = 9;              // one bit above 255 marks bus-off
   localparam int REC_W = 8;
   localparam logic [TEC_W-1:0] TEC_BUS_OFF_FLAG_LIMIT = 9'h0ff; // bus-off above
   localparam logic [TEC_W-1:0] TEC_WARN = 9'h060;        // 96
   localparam logic [REC_W-1:0] REC_WARN = 8'h60;         // 96
   localparam logic [REC_W-1:0] REC_PASSIVE = 8'h7f;      // 127
   localparam logic [REC_W-1:0] REC_RESUME = 8'h77;       // 119
   localparam logic [3:0] ERR_STEP_BIG = 4'h8;            // +8 step
   localparam logic [7:0] RECOVERY_SEQS = 8'h80;          // 128 x 11 bits
   // ------------------------------------------------------------------
   // events from the protocol machine and message handler (same clock)
   // ------------------------------------------------------------------
   typedef struct packed {
      logic tx_err;     // transmit error seen, +8
      logic tx_ok;      // frame sent without error, -1
      logic rx_err;     // receive error, +1
      logic rx_err8;    // severe receive error, +8
      logic rx_ok;      // frame received without error, -1
      logic rx_done;    // end of any reception
      logic rx_valid;   // end of an error free frame
      logic rec11;      // one run of 11 recessive bits
      logic bus_act;    // reception or transmission in progress
      logic bus_edge;   // transition seen on the bus
      logic pm_idle;    // all internal activity stopped
      logic sleep_mode; // controller currently asleep
      logic ovr_tx;     // transmit data not fetched in time
      logic ovr_rx;     // receive data not stored in time
      logic ovr_id;     // identifier not fetched for compare
   } ces_evt_t;
   // controls back to the protocol machine and message handler
   typedef struct packed {
      logic keep_tx_req;  // leave transmit request pending, resend
      logic block_rx_flg; // set no receive flags for this message
      logic discard_rx;   // drop the incoming message
      logic pm_reset;     // protocol machine hard reset
      logic sleep_grant;  // sleep request accepted
   } ces_ctl_t;
   typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_INIT} ces_state_t;
endpackage
`default_nettype wire

// ==== verilog/ces_err_cnt.sv ====
// transmit and receive error counters with fault confinement steps
`default_nettype none
module ces_err_cnt #(
   parameter int TW = ces_pkg::TEC_W,
   parameter int RW = ces_pkg::REC_W
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_tec_inc8,
   input wire logic i_tec_dec,
   input wire logic i_rec_inc1,
   input wire logic i_rec_inc8,
   input wire logic i_rec_dec,
   input wire logic i_clear,
   output logic [TW-1:0] o_tec,
   output logic [RW-1:0] o_rec
);
   // ------------------------------------------------------------------
   // next values
   // ------------------------------------------------------------------
   logic [TW-1:0] tec_q;
   logic [TW-1:0] tec_d;
   logic [RW-1:0] rec_q;
   logic [RW-1:0] rec_d;
   logic [RW:0] rec_sum;
   logic [TW:0] tec_sum;
   // saturating add keeps counters from wrapping
   assign tec_sum = {1'b0, tec_q} + (TW+1)'(ces_pkg::ERR_STEP_BIG);
   assign rec_sum = {1'b0, rec_q} + (RW+1)'(i_rec_inc8 ?
                    ces_pkg::ERR_STEP_BIG : 4'h1);
   always_comb
   begin
      tec_d = tec_q;
      rec_d = rec_q;
      if (i_clear)
      begin
         tec_d = '0;
         rec_d = '0;
      end
      else
      begin
         // transmit side: +8 on error, -1 on success
         if (i_tec_inc8)
            tec_d = tec_sum[TW] ? '1 : tec_sum[TW-1:0];
         else if (i_tec_dec && tec_q != '0)
            tec_d = tec_q - TW'(1);
         // receive side: above passive level a success drops to 119
         if (i_rec_inc1 || i_rec_inc8)
            rec_d = rec_sum[RW] ? '1 : rec_sum[RW-1:0];
         else if (i_rec_dec && rec_q > ces_pkg::REC_PASSIVE)
            rec_d = ces_pkg::REC_RESUME;
         else if (i_rec_dec && rec_q != '0)
            rec_d = rec_q - RW'(1);
      end
   end
   // ------------------------------------------------------------------
   // counter flops
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tec_q <= '0;
         rec_q <= '0;
      end
      else
      begin
         tec_q <= tec_d;
         rec_q <= rec_d;
      end
   end
   assign o_tec = tec_q;
   assign o_rec = rec_q;
endmodule
`default_nettype wire

// ==== verilog/ces_top.sv ====
// error status register, error counters and interrupts of the controller
`default_nettype none
module ces_top (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [15:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   input wire logic i_init_req,
   input wire logic i_sleep_req,
   input wire logic i_hard_reset,
   input wire ces_pkg::ces_evt_t i_evt,
   output ces_pkg::ces_ctl_t o_ctl,
   output logic o_status_irq,
   output logic o_err_irq
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic valid_q;                  // error free frame seen
   logic wake_q;                   // sleep cancelled or refused
   logic over_q;                   // RAM overrun seen
   logic receive_warning_flag_q;                   // receive warning
   logic transmit_warning_flag_q;                   // transmit warning
   logic bus_off_flag_q;                   // previous bus-off, for change detect
   logic status_irq_q;             // status change pulse
   logic over_irq_q;               // overrun interrupt pulse
   logic [7:0] rdata_q;            // read data
   logic [7:0] recov_q;            // recessive run counter in bus-off
   ces_pkg::ces_ctl_t ctl_q;       // registered controls
   ces_pkg::ces_state_t state_q;   // init handshake state
   ces_pkg::ces_state_t state_d;
   logic [ces_pkg::TEC_W-1:0] transmit_error_count;
   logic [ces_pkg::REC_W-1:0] receive_error_count;
   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   wire wr_status = i_sfr_wr && (i_sfr_addr == ces_pkg::ADDR_ERR_STATUS);
   wire clr_valid = wr_status && i_sfr_wdata[ces_pkg::BIT_VALID];
   wire clr_wake = wr_status && i_sfr_wdata[ces_pkg::BIT_WAKE];
   wire clr_over = wr_status && i_sfr_wdata[ces_pkg::BIT_OVER];
   wire bus_off_flag = transmit_error_count > ces_pkg::TEC_BUS_OFF_FLAG_LIMIT;
   wire recov_done = bus_off_flag && i_evt.rec11 &&
                     (recov_q == ces_pkg::RECOVERY_SEQS - 8'h01);
   wire hard_rst = i_hard_reset && bus_off_flag;
   wire cnt_clear = recov_done || hard_rst;
   wire init_granted = (state_q == ces_pkg::ST_INIT);
   // any overrun raises the flag; each kind also steers the handler
   wire ovr_any = i_evt.ovr_tx || i_evt.ovr_rx || i_evt.ovr_id;
   wire set_wake = (i_evt.sleep_mode && i_evt.bus_edge) ||
                   (i_sleep_req && i_evt.bus_act);
   // sleep accepted only when idle and wake not pending
   wire sleep_ok = i_sleep_req && !i_evt.bus_act && !wake_q;
   // valid only for frames whose data was stored
   wire set_valid = i_evt.rx_valid && !i_evt.ovr_rx;
   wire [7:0] status_rd = {bus_off_flag, receive_warning_flag_q, transmit_warning_flag_q, 1'b0, init_granted,
                           valid_q, wake_q, over_q};
   // counters read as 8 bits, saturated once past 255
   wire [7:0] tec_rd = bus_off_flag ? 8'hff : transmit_error_count[7:0];
   wire [7:0] rd_mux =
      (i_sfr_addr == ces_pkg::ADDR_ERR_STATUS) ? status_rd :
      (i_sfr_addr == ces_pkg::ADDR_TX_ERR_CNT) ? tec_rd :
      (i_sfr_addr == ces_pkg::ADDR_RX_ERR_CNT) ? receive_error_count : 8'h00;
   // ------------------------------------------------------------------
   // error counters
   // ------------------------------------------------------------------
   ces_err_cnt #(
      .TW(ces_pkg::TEC_W),
      .RW(ces_pkg::REC_W)
   ) u_ces_err_cnt (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tec_inc8(i_evt.tx_err),
      .i_tec_dec(i_evt.tx_ok),
      .i_rec_inc1(i_evt.rx_err),
      .i_rec_inc8(i_evt.rx_err8),
      .i_rec_dec(i_evt.rx_ok),
      .i_clear(cnt_clear),
      .o_tec(transmit_error_count),
      .o_rec(receive_error_count)
   );
   // ------------------------------------------------------------------
   // init handshake: request waits for idle, never while bus-off
   // ------------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ces_pkg::ST_RUN:
            if (i_init_req && !bus_off_flag)
               state_d = ces_pkg::ST_WAIT;
         ces_pkg::ST_WAIT:
            if (!i_init_req)
               state_d = ces_pkg::ST_RUN;
            else if (!i_evt.bus_act && i_evt.pm_idle && !bus_off_flag)
               state_d = ces_pkg::ST_INIT;
         ces_pkg::ST_INIT:
            if (!i_init_req)
               state_d = ces_pkg::ST_RUN;
      endcase
      if (hard_rst)
         state_d = ces_pkg::ST_INIT;
   end
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_q <= ces_pkg::ST_RUN;
      else
         state_q <= state_d;
   end
   // ------------------------------------------------------------------
   // write-one-to-clear flags; the set term always wins
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         valid_q <= ces_pkg::ERR_STATUS_RST[ces_pkg::BIT_VALID];
         wake_q <= ces_pkg::ERR_STATUS_RST[ces_pkg::BIT_WAKE];
         over_q <= ces_pkg::ERR_STATUS_RST[ces_pkg::BIT_OVER];
      end
      else
      begin
         valid_q <= set_valid ||
                    (valid_q && !clr_valid && !i_init_req);
         wake_q <= set_wake ||
                   (wake_q && !clr_wake && !i_init_req);
         over_q <= ovr_any || (over_q && !clr_over);
      end
   end
   // ------------------------------------------------------------------
   // warning levels sampled at the end of each reception
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         receive_warning_flag_q <= 1'b0;
         transmit_warning_flag_q <= 1'b0;
      end
      else if (i_evt.rx_done)
      begin
         receive_warning_flag_q <= receive_error_count >= ces_pkg::REC_WARN;
         transmit_warning_flag_q <= transmit_error_count >= ces_pkg::TEC_WARN;
      end
   end
   // ------------------------------------------------------------------
   // bus-off recovery: count runs of 11 recessive bits
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         recov_q <= 8'h00;
      else if (!bus_off_flag || cnt_clear)
         recov_q <= 8'h00;
      else if (i_evt.rec11)
         recov_q <= recov_q + 8'h01;
   end
   // ------------------------------------------------------------------
   // interrupts: status change pulse, overrun pulse
   // ------------------------------------------------------------------
   wire receive_warning_flag_nx = i_evt.rx_done ? (receive_error_count >= ces_pkg::REC_WARN) : receive_warning_flag_q;
   wire transmit_warning_flag_nx = i_evt.rx_done ? (transmit_error_count >= ces_pkg::TEC_WARN) : transmit_warning_flag_q;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bus_off_flag_q <= 1'b0;
         status_irq_q <= 1'b0;
         over_irq_q <= 1'b0;
      end
      else
      begin
         bus_off_flag_q <= bus_off_flag;
         status_irq_q <= (bus_off_flag != bus_off_flag_q) ||
                         (receive_warning_flag_nx != receive_warning_flag_q) ||
                         (transmit_warning_flag_nx != transmit_warning_flag_q);
         over_irq_q <= ovr_any;
      end
   end
   // error line stays high while wake is pending
   assign o_err_irq = wake_q || over_irq_q;
   assign o_status_irq = status_irq_q;
   // ------------------------------------------------------------------
   // controls to the protocol machine and read data
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctl_q <= '0;
         rdata_q <= ces_pkg::CNT_RST;
      end
      else
      begin
         ctl_q.keep_tx_req <= i_evt.ovr_tx;
         ctl_q.block_rx_flg <= i_evt.ovr_rx;
         ctl_q.discard_rx <= i_evt.ovr_id;
         ctl_q.pm_reset <= hard_rst;
         ctl_q.sleep_grant <= sleep_ok;
         if (i_sfr_rd)
            rdata_q <= rd_mux;
      end
   end
   assign o_ctl = ctl_q;
   assign o_sfr_rdata = rdata_q;
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   a_bus_off_flag_irq_edge: assert property ($changed(bus_off_flag) |=> o_status_irq)
      else $error("bus-off change without status interrupt");
   a_bus_off_flag_reads_sat: assert property (bus_off_flag |-> tec_rd == 8'hff)
      else $error("bus-off while counter reads below 255");
   a_w1c_zero_keeps: assert property (wr_status && !clr_valid &&
      !i_init_req && valid_q |=> valid_q)
      else $error("zero write changed valid flag");
   a_set_beats_clr: assert property (clr_over && ovr_any |=> over_q)
      else $error("overrun set lost to clear");
   a_init_in_bus_off_flag: assert property (bus_off_flag && !hard_rst &&
      state_q != ces_pkg::ST_INIT |=> !init_granted)
      else $error("init granted during bus-off");
   a_wake_holds_irq: assert property (wake_q |-> o_err_irq)
      else $error("error line low while wake set");
   a_sleep_refused: assert property (i_sleep_req && i_evt.bus_act
      |=> wake_q && !o_ctl.sleep_grant)
      else $error("busy sleep request not refused");
   a_over_irq_time: assert property (ovr_any |=> over_q && o_err_irq)
      else $error("overrun flag or interrupt missing");
   a_receive_warning_flag_sample: assert property (i_evt.rx_done
      |=> receive_warning_flag_q == ($past(receive_error_count) >= ces_pkg::REC_WARN))
      else $error("receive warning wrong after reception");
   a_recover_clear: assert property (recov_done |=> !bus_off_flag ##1 !bus_off_flag_q)
      else $error("bus-off not left after recovery");
   a_hard_rst_init: assert property (hard_rst |=> init_granted &&
      o_ctl.pm_reset)
      else $error("hard reset did not enter init");
   a_init_clr_valid: assert property (i_init_req && !set_valid
      |=> !valid_q)
      else $error("valid not cleared by init request");
   c_bus_off_flag_entry: cover property (!bus_off_flag ##1 bus_off_flag);
   c_init_grant: cover property (i_init_req ##[1:50] init_granted);
   c_wake_clear: cover property (wake_q ##1 clr_wake ##1 !wake_q);
   c_overrun: cover property (i_evt.ovr_rx ##1 over_q);
endmodule
`default_nettype wire

// ==== dv/ces_bus_node.sv ====
// far-side node model: frames and bus events toward the status block
`default_nettype none
module ces_bus_node (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_go,
   input wire logic [1:0] i_kind,
   input wire logic [5:0] i_len,
   input wire ces_pkg::ces_evt_t i_extra,
   output ces_pkg::ces_evt_t o_evt,
   output logic o_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] cnt_q; // clocks left in the frame
   logic [1:0] kind_q; // outcome of the frame
   wire logic act_w; // frame on the bus
   wire logic res_w; // outcome pulse, one clock before the end
   wire logic end_w; // end of frame
   // -----------------------------------------------------------------
   // frame timer, never shorter than 16 clocks
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= 7'h00;
         kind_q <= 2'h0;
      end
      else if (i_go && cnt_q == 7'h00)
      begin
         cnt_q <= {1'b0, i_len} + 7'h10;
         kind_q <= i_kind;
      end
      else if (cnt_q != 7'h00)
         cnt_q <= cnt_q - 7'h01;
   end
   assign act_w = cnt_q > 7'h01;
   assign res_w = cnt_q == 7'h02;
   assign end_w = cnt_q == 7'h01;
   assign o_busy = cnt_q != 7'h00;
   // outcome pulses ahead of the end so counters settle first
   always_comb
   begin
      o_evt = i_extra;
      o_evt.bus_act = act_w;
      o_evt.pm_idle = !o_busy;
      o_evt.rx_done = i_extra.rx_done | end_w;
      o_evt.rx_valid = i_extra.rx_valid | (end_w && kind_q == 2'h0);
      o_evt.rx_ok = i_extra.rx_ok | (res_w && kind_q == 2'h0);
      o_evt.rx_err = i_extra.rx_err | (res_w && kind_q == 2'h1);
      o_evt.tx_err = i_extra.tx_err | (res_w && kind_q == 2'h2);
      o_evt.tx_ok = i_extra.tx_ok | (res_w && kind_q == 2'h3);
   end
endmodule
`default_nettype wire

// ==== dv/tb_ces_top.sv ====
// self-checking bench of the error status and error counter block
`default_nettype none
module tb_ces_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_rst_n, i_sfr_wr, i_sfr_rd, i_init_req; // design inputs
   logic i_sleep_req, i_hard_reset, go, busy, irq_seen;
   logic o_status_irq, o_err_irq; // interrupt outputs
   logic [15:0] i_sfr_addr;
   logic [7:0] i_sfr_wdata, o_sfr_rdata, rd_v;
   logic [1:0] kind; // frame outcome asked of the node
   logic [5:0] len;
   ces_pkg::ces_evt_t extra, evt, e;
   ces_pkg::ces_ctl_t o_ctl, ctl_seen;
   int err_count, n_tests, tec_e, rec_e;
   logic bus_off_flag_e, receive_warning_flag_e, transmit_warning_flag_e, init_e, valid_e, wake_e, over_e;
   logic [31:0] seed; // xorshift state
   ces_top u_ces_top (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
      .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
      .i_init_req(i_init_req), .i_sleep_req(i_sleep_req),
      .i_hard_reset(i_hard_reset), .i_evt(evt), .o_ctl(o_ctl),
      .o_status_irq(o_status_irq), .o_err_irq(o_err_irq));
   ces_bus_node u_ces_bus_node (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_go(go), .i_kind(kind), .i_len(len), .i_extra(extra),
      .o_evt(evt), .o_busy(busy));
   // 40 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // catch pulses once the edge has settled
   always @(posedge i_clk)
   begin
      #2;
      if (o_status_irq === 1'b1)
         irq_seen = 1'b1;
      ctl_seen = ctl_seen | o_ctl;
   end
   // -----------------------------------------------------------------
   // expectation, compare and bus helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction
   function automatic logic [7:0] stat_exp();
      return {bus_off_flag_e, receive_warning_flag_e, transmit_warning_flag_e, 1'b0, init_e, valid_e, wake_e, over_e};
   endfunction
   task automatic chk(input string nm, input logic [7:0] s, x);
      n_tests++;
      if (s !== x)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_sfr_addr = a;
      i_sfr_wdata = d;
      i_sfr_wr = 1'b1;
      @(negedge i_clk);
      i_sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(negedge i_clk);
      i_sfr_addr = a;
      i_sfr_rd = 1'b1;
      @(negedge i_clk);
      i_sfr_rd = 1'b0;
      rd_v = o_sfr_rdata;
   endtask
   task automatic pulse(input ces_pkg::ces_evt_t p);
      @(negedge i_clk);
      extra = p;
      @(negedge i_clk);
      extra = '0;
   endtask
   task automatic sleep_pulse();
      @(negedge i_clk);
      i_sleep_req = 1'b1;
      @(negedge i_clk);
      i_sleep_req = 1'b0;
   endtask
   task automatic chk_regs();
      rd(ces_pkg::ADDR_ERR_STATUS);
      chk("status", rd_v, stat_exp());
      rd(ces_pkg::ADDR_TX_ERR_CNT);
      chk("tx_count", rd_v, bus_off_flag_e ? 8'hff : tec_e[7:0]);
      rd(ces_pkg::ADDR_RX_ERR_CNT);
      chk("rx_count", rd_v, rec_e[7:0]);
   endtask
   // one frame from the node; mid 1 asks sleep, mid 2 asks init
   task automatic frame(input logic [1:0] k, input int mid);
      logic [2:0] prev;
      int n;
      prev = {bus_off_flag_e, receive_warning_flag_e, transmit_warning_flag_e};
      seed = xs(seed);
      @(negedge i_clk);
      irq_seen = 1'b0;
      ctl_seen = '0;
      go = 1'b1;
      kind = k;
      len = seed[5:0];
      @(negedge i_clk);
      go = 1'b0;
      if (mid == 1)
      begin
         sleep_pulse();
         wake_e = 1'b1;
      end
      if (mid == 2)
      begin
         i_init_req = 1'b1;
         rd(ces_pkg::ADDR_ERR_STATUS);
         chk("init_mid", rd_v[3], 1'b0);
         {init_e, valid_e, wake_e} = 3'b100;
      end
      n = 0;
      while (busy === 1'b1 && n < 200)
      begin
         @(negedge i_clk);
         n++;
      end
      // a frame that never ends counts against the run
      if (n >= 200)
         err_count++;
      repeat (4) @(negedge i_clk);
      case (k)
         2'h0: rec_e = rec_e > 127 ? 119 : (rec_e > 0 ? rec_e - 1 : 0);
         2'h1: rec_e = rec_e + 1;
         2'h2: tec_e = tec_e + 8;
         default: tec_e = tec_e > 0 ? tec_e - 1 : 0;
      endcase
      valid_e = valid_e | (k == 2'h0);
      bus_off_flag_e = tec_e > 255;
      receive_warning_flag_e = rec_e >= 96;
      transmit_warning_flag_e = tec_e >= 96;
      chk_regs();
      chk("status_irq", irq_seen, prev != {bus_off_flag_e, receive_warning_flag_e, transmit_warning_flag_e});
   endtask
   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog well past the expected run
   initial
   begin
      #(90000 * 25);
      err_count++;
      give_verdict();
   end
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      {i_rst_n, i_sfr_wr, i_sfr_rd, i_sleep_req, i_hard_reset, go} = '0;
      {i_sfr_addr, i_sfr_wdata, kind, len, extra, e, ctl_seen} = '0;
      {err_count, n_tests, tec_e, rec_e} = '0;
      {bus_off_flag_e, receive_warning_flag_e, transmit_warning_flag_e, valid_e, wake_e, over_e, irq_seen} = '0;
      i_init_req = 1'b1;
      init_e = 1'b1;
      seed = 32'had614736;
      repeat (20) @(posedge i_clk);
      chk("rdata_in_reset", o_sfr_rdata, 8'h00);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (3) @(negedge i_clk);
      chk_regs();
      i_init_req = 1'b0;
      init_e = 1'b0;
      repeat (3) @(negedge i_clk);
      chk_regs();
      wr(ces_pkg::ADDR_TX_ERR_CNT, 8'hff);
      wr(ces_pkg::ADDR_RX_ERR_CNT, 8'hff);
      chk_regs();
      rd(16'hffb7);
      chk("unmapped", rd_v, 8'h00);
      frame(2'h1, 2);
      i_init_req = 1'b0;
      init_e = 1'b0;
      repeat (120)
      begin
         frame(seed[9:8] == 2'h2 ? {1'b1, ~seed[10]} : seed[9:8], 0);
         if (seed[12])
         begin
            wr(ces_pkg::ADDR_ERR_STATUS, seed[20:13]);
            {valid_e, wake_e, over_e} &= ~seed[15:13];
         end
      end
      while (rec_e < 100) frame(2'h1, 0);
      // severe receive errors push past the passive level
      e = '0;
      e.rx_err8 = 1'b1;
      repeat (4) pulse(e);
      rec_e = rec_e + 32;
      chk_regs();
      repeat (25) frame(2'h0, 0);
      while (tec_e < 104) frame(2'h2, 0);
      while (tec_e > 0) frame(2'h3, 0);
      // overruns: each kind its own control pulse
      wr(ces_pkg::ADDR_ERR_STATUS, 8'h07);
      {valid_e, wake_e, over_e} = '0;
      for (int i = 0; i < 3; i++)
      begin
         pulse(ces_pkg::ces_evt_t'(15'h0001 << i));
         chk("ctl", o_ctl, 8'h04 << i);
         chk("err_irq_pulse", o_err_irq, 1'b1);
      end
      e = '0;
      e.ovr_rx = 1'b1;
      e.rx_valid = 1'b1;
      pulse(e);
      over_e = 1'b1;
      chk_regs();
      @(negedge i_clk);
      i_sfr_addr = ces_pkg::ADDR_ERR_STATUS;
      i_sfr_wdata = 8'h05;
      i_sfr_wr = 1'b1;
      extra.rx_valid = 1'b1;
      extra.ovr_tx = 1'b1;
      @(negedge i_clk);
      i_sfr_wr = 1'b0;
      extra = '0;
      chk("keep_tx", o_ctl.keep_tx_req, 1'b1);
      {valid_e, over_e} = 2'b11;
      chk_regs();
      // sleep refused during a frame, then granted when idle
      frame(2'h0, 1);
      chk("sleep_grant", ctl_seen.sleep_grant, 1'b0);
      chk("err_irq_hold", o_err_irq, 1'b1);
      wr(ces_pkg::ADDR_ERR_STATUS, 8'h00);
      chk_regs();
      wr(ces_pkg::ADDR_ERR_STATUS, 8'h02);
      wake_e = 1'b0;
      chk_regs();
      chk("err_irq_off", o_err_irq, 1'b0);
      ctl_seen = '0;
      sleep_pulse();
      repeat (2) @(negedge i_clk);
      chk("sleep_idle", ctl_seen.sleep_grant, 1'b1);
      e = '0;
      e.sleep_mode = 1'b1;
      e.bus_edge = 1'b1;
      pulse(e);
      wake_e = 1'b1;
      chk_regs();
      // bus-off entry at the counter boundary, recovery by idle runs
      while (!bus_off_flag_e) frame(2'h2, 0);
      i_init_req = 1'b1;
      {valid_e, wake_e} = '0;
      repeat (10) @(negedge i_clk);
      chk_regs();
      e = '0;
      e.rec11 = 1'b1;
      repeat (127) pulse(e);
      chk_regs();
      irq_seen = 1'b0;
      pulse(e);
      {bus_off_flag_e, tec_e, rec_e, init_e} = {1'b0, 32'h0, 32'h0, 1'b1};
      repeat (4) @(negedge i_clk);
      chk("bus_off_flag_irq", irq_seen, 1'b1);
      chk_regs();
      i_init_req = 1'b0;
      init_e = 1'b0;
      repeat (3) @(negedge i_clk);
      while (!bus_off_flag_e) frame(2'h2, 0);
      i_init_req = 1'b1;
      ctl_seen = '0;
      @(negedge i_clk);
      i_hard_reset = 1'b1;
      @(negedge i_clk);
      i_hard_reset = 1'b0;
      repeat (4) @(negedge i_clk);
      {bus_off_flag_e, tec_e, rec_e, init_e} = {1'b0, 32'h0, 32'h0, 1'b1};
      chk("pm_reset", ctl_seen.pm_reset, 1'b1);
      chk_regs();
      give_verdict();
   end
endmodule
`default_nettype wire
